// ==== pkg/dtp_pkg.sv ====
// Constants, types and decode helpers for the tuning parameter bank.
package dtp_pkg;

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int NUM_REGS = 32'h0000_000f;
  localparam int IDX_W    = 32'h0000_0004;
  localparam int WORD_W   = 32'h0000_0010;
  localparam int ERR_W    = 32'h0000_0008;
  localparam int DISP_W   = 32'h0000_0003;

  typedef logic [WORD_W-1:0] dtp_word_t;
  typedef logic [IDX_W-1:0]  dtp_idx_t;
  typedef logic [ERR_W-1:0]  dtp_err_t;

  typedef struct packed {
    logic     hit;
    dtp_idx_t idx;
  } dtp_hit_t;

  typedef struct packed {
    logic locked;
    logic freq_ok;
  } dtp_lock_t;

  // ---------------------------------------------------------------------
  // Register indices, holding-register addresses, ranges and resets
  // ---------------------------------------------------------------------
  localparam dtp_idx_t IDX_OL_MODE  = 4'h0;
  localparam dtp_idx_t IDX_OL_LEVEL = 4'h1;
  localparam dtp_idx_t IDX_OL_DECEL = 4'h2;
  localparam dtp_idx_t IDX_LOCK     = 4'h3;
  localparam dtp_idx_t IDX_AM_GAIN  = 4'h4;
  localparam dtp_idx_t IDX_START_F  = 4'h5;
  localparam dtp_idx_t IDX_CARRIER  = 4'h6;
  localparam dtp_idx_t IDX_INIT     = 4'h7;
  localparam dtp_idx_t IDX_REGION   = 4'h8;
  localparam dtp_idx_t IDX_SCALE    = 4'h9;
  localparam dtp_idx_t IDX_STOP_KEY = 4'ha;
  localparam dtp_idx_t IDX_RESTART  = 4'hb;
  localparam dtp_idx_t IDX_STOP     = 4'hc;
  localparam dtp_idx_t IDX_REACTIVE = 4'hd;
  localparam dtp_idx_t IDX_DISPLAY  = 4'he;

  localparam dtp_word_t REG_ADDR [NUM_REGS] = '{
    16'h0092, 16'h0093, 16'h0094, 16'h0095, 16'h0096,
    16'h0098, 16'h0099, 16'h009a, 16'h009b, 16'h009c,
    16'h009d, 16'h009e, 16'h00a0, 16'h00e8, 16'h00e9};

  localparam dtp_word_t REG_MIN [NUM_REGS] = '{
    16'h0000, 16'h07d0, 16'h0001, 16'h0000, 16'h0000,
    16'h0005, 16'h0014, 16'h0000, 16'h0000, 16'h0001,
    16'h0000, 16'h0000, 16'h0000, 16'h0032, 16'h0001};

  localparam dtp_word_t REG_MAX [NUM_REGS] = '{
    16'h0002, 16'h3a98, 16'h012c, 16'h0003, 16'h00ff,
    16'h0063, 16'h008c, 16'h0002, 16'hffff, 16'h03e7,
    16'h0001, 16'h0001, 16'h0001, 16'h00c8, 16'h0007};

  localparam dtp_word_t REG_RESET [NUM_REGS] = '{
    16'h0001, 16'h3a98, 16'h0001, 16'h0000, 16'h0064,
    16'h0005, 16'h0014, 16'h0000, 16'h0000, 16'h000a,
    16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0001};

  // Only the regional default selection refuses network writes.
  localparam logic [NUM_REGS-1:0] REG_WRITABLE = 15'h7eff;

  // ---------------------------------------------------------------------
  // Option codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] OL_OFF            = 2'h0;
  localparam logic [1:0] OL_ACCEL_CONST    = 2'h1;
  localparam logic [1:0] OL_CONST_ONLY     = 2'h2;
  localparam logic [1:0] LOCK_TERM         = 2'h0;
  localparam logic [1:0] LOCK_TERM_FREQ_OK = 2'h1;
  localparam logic [1:0] LOCK_ALL          = 2'h2;
  localparam logic [1:0] LOCK_ALL_FREQ_OK  = 2'h3;
  localparam dtp_word_t  INIT_TRIP         = 16'h0000;
  localparam dtp_word_t  INIT_PARAMS       = 16'h0001;
  localparam dtp_word_t  INIT_BOTH         = 16'h0002;
  localparam logic       KEY_ENABLED       = 1'h0;
  localparam logic       RESTART_MATCH     = 1'h1;
  localparam logic       STOP_COAST        = 1'h1;

  // ---------------------------------------------------------------------
  // Answer codes
  // ---------------------------------------------------------------------
  localparam dtp_err_t ERR_NONE      = 8'h00;
  localparam dtp_err_t ERR_READ_ONLY = 8'h01;
  localparam dtp_err_t ERR_BAD_ADDR  = 8'h02;
  localparam dtp_err_t ERR_BAD_VALUE = 8'h03;
  localparam dtp_err_t ERR_LOCKED    = 8'h04;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic dtp_hit_t dtp_lookup(input dtp_word_t addr);
    dtp_hit_t r;
    r.hit = 1'b0;
    r.idx = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR[i] == addr) begin
        r.hit = 1'b1;
        r.idx = i[IDX_W-1:0];
      end
    end
    return r;
  endfunction : dtp_lookup

  function automatic dtp_lock_t dtp_lock_eval(input logic [1:0] mode,
                                              input logic       term);
    dtp_lock_t r;
    r.locked  = (mode == LOCK_ALL) || (mode == LOCK_ALL_FREQ_OK) ||
                (term && ((mode == LOCK_TERM) ||
                          (mode == LOCK_TERM_FREQ_OK)));
    r.freq_ok = !r.locked || (mode == LOCK_TERM_FREQ_OK) ||
                (mode == LOCK_ALL_FREQ_OK);
    return r;
  endfunction : dtp_lock_eval

endpackage : dtp_pkg

// ==== pkg/dtp_store_if.sv ====
// Port bundle between the bank logic and its parameter store.
`timescale 1ns/1ns
interface dtp_store_if;
  logic              ce;
  logic              we;
  dtp_pkg::dtp_idx_t waddr;
  dtp_pkg::dtp_word_t wdata;
  dtp_pkg::dtp_idx_t raddr;
  dtp_pkg::dtp_word_t rdata;

  modport host  (output ce, output we, output waddr, output wdata,
                 output raddr, input rdata);
  modport store (input ce, input we, input waddr, input wdata,
                 input raddr, output rdata);
endinterface : dtp_store_if

// ==== hdl/dtp_param_store.sv ====
// Parameter word store with registered read data.
`timescale 1ns/1ns
module dtp_param_store #(
  parameter int DEPTH = dtp_pkg::NUM_REGS
) (
  input wire logic clk,
  input wire logic rst_n,
  dtp_store_if.store bus
);

  dtp_pkg::dtp_word_t mem_r [DEPTH];
  dtp_pkg::dtp_word_t rdata_r;

  assign bus.rdata = rdata_r;

  // Reset loads every word with its default so reads are never unknown.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= dtp_pkg::REG_RESET[i];
      end
      rdata_r <= '0;
    end else if (bus.ce) begin
      if (bus.we) begin
        mem_r[bus.waddr] <= bus.wdata;
      end
      rdata_r <= mem_r[bus.raddr];
    end
  end

endmodule : dtp_param_store

// ==== hdl/dtp_param_bank.sv ====
// Holding-register bank for the drive fine-tuning parameters.
`timescale 1ns/1ns

// Function
// - Each parameter is a holding register read at its address; all but regional default selection are also written there.
// - Overload limit mode: 0 off, 1 accel and constant, 2 constant only.
// - Overload limit level holds 2000 to 15000, 0.01 percent steps.
// - Overload deceleration rate holds 1 to 300, 0.1 second units.
// - Lock 0/1 blocks writes while lock terminal on; 2/3 always.
// - Lock 1/3 still allow output frequency setting writes.
// - Reactive current calibration holds 50 to 200 percent.
// - Analog output gain holds 0 to 255.
// - Start frequency holds 5 to 99, 0.1 Hz units.
// - Carrier frequency holds raw 20 to 140.
// - Init codes: 0 trip history, 1 defaults, 2 both.
// - Regional default selection refuses network writes.
// - Display scale factor holds 1 to 999.
// - Stop key enabled by code 0, disabled by code 1.
// - After free-run cancel restart from 0 Hz or matched frequency.
// - Networked display select accepts codes 1 to 7.
// - Stop method 0 decelerates, 1 coasts to stop.
module dtp_param_bank (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic                          req_valid,
  input  wire logic                          req_write,
  input  wire logic [15:0]                   req_addr,
  input  wire logic [15:0]                   req_wdata,
  input  wire logic                          lock_input_terminal,
  output logic                               resp_valid,
  output logic [15:0]                        resp_rdata,
  output logic [7:0]                         resp_err,
  output logic                               param_write_locked,
  output logic                               freq_setting_write_ok,
  output logic                               overload_limit_accel,
  output logic                               overload_limit_const,
  output logic                               trip_history_clear,
  output logic                               param_defaults_restore,
  output logic                               stop_key_enabled,
  output logic                               coast_restart_match,
  output logic                               coast_to_stop,
  output logic [2:0]                         display_select
);

  // ---------------------------------------------------------------------
  // Local helpers
  // ---------------------------------------------------------------------
  function automatic logic idx_is(input dtp_pkg::dtp_idx_t i,
                                  input dtp_pkg::dtp_idx_t want);
    return i == want;
  endfunction : idx_is

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic                p1_valid_r;
  logic                p1_write_r;
  dtp_pkg::dtp_err_t   p1_err_r;
  dtp_pkg::dtp_word_t  p1_wdata_r;
  logic                resp_valid_r;
  dtp_pkg::dtp_word_t  resp_rdata_r;
  dtp_pkg::dtp_err_t   resp_err_r;

  // Shadows of the codes that steer logic, kept beside the store so that
  // checks and decoded outputs need no read cycle.
  logic [1:0]          ol_mode_r;
  logic [1:0]          lock_mode_r;
  logic                stop_key_r;
  logic                restart_r;
  logic                stop_r;
  logic [2:0]          display_r;

  logic                locked_r;
  logic                freq_ok_r;
  logic                ol_accel_r;
  logic                ol_const_r;
  logic                trip_clear_r;
  logic                defaults_r;
  logic                key_en_r;
  logic                match_r;
  logic                coast_r;

  // ---------------------------------------------------------------------
  // Request decode and checks
  // ---------------------------------------------------------------------
  dtp_pkg::dtp_hit_t   req_hit;
  dtp_pkg::dtp_idx_t   req_idx;
  dtp_pkg::dtp_word_t  lo_lim;
  dtp_pkg::dtp_word_t  hi_lim;
  logic                req_fire;
  logic                in_range;
  logic                writable;
  dtp_pkg::dtp_lock_t  lock_now;
  logic                lock_blocks;
  dtp_pkg::dtp_err_t   req_err;
  logic                wr_ok;

  assign req_fire = clk_en & req_valid;
  assign req_hit  = dtp_pkg::dtp_lookup(req_addr);
  assign req_idx  = req_hit.idx;
  assign lo_lim   = dtp_pkg::REG_MIN[req_idx];
  assign hi_lim   = dtp_pkg::REG_MAX[req_idx];
  // One table covers every listed range, so each register is bounded here.
  assign in_range = (req_wdata >= lo_lim) && (req_wdata <= hi_lim);
  assign writable = dtp_pkg::REG_WRITABLE[req_idx];

  // The lock register itself stays writable so software can always undo
  // a lock it set.
  assign lock_now    = dtp_pkg::dtp_lock_eval(lock_mode_r,
                                              lock_input_terminal);
  assign lock_blocks = lock_now.locked &&
                       !idx_is(req_idx, dtp_pkg::IDX_LOCK);

  // Address first, then write permission, lock and value range.
  assign req_err = !req_hit.hit ? dtp_pkg::ERR_BAD_ADDR :
                   !req_write   ? dtp_pkg::ERR_NONE :
                   !writable    ? dtp_pkg::ERR_READ_ONLY :
                   lock_blocks  ? dtp_pkg::ERR_LOCKED :
                   !in_range    ? dtp_pkg::ERR_BAD_VALUE :
                                  dtp_pkg::ERR_NONE;

  assign wr_ok = req_fire & req_write & (req_err == dtp_pkg::ERR_NONE);

  // ---------------------------------------------------------------------
  // Parameter store
  // ---------------------------------------------------------------------
  dtp_store_if st ();

  assign st.ce    = clk_en;
  assign st.we    = wr_ok;
  assign st.waddr = req_idx;
  assign st.wdata = req_wdata;
  assign st.raddr = req_idx;

  dtp_param_store #(
    .DEPTH (dtp_pkg::NUM_REGS)
  ) u_store (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (st.store)
  );

  // ---------------------------------------------------------------------
  // Shadow next values
  // ---------------------------------------------------------------------
  logic                wr_ol_mode;
  logic                wr_lock;
  logic                wr_init;
  logic                wr_key;
  logic                wr_restart;
  logic                wr_stop;
  logic                wr_display;
  logic [1:0]          ol_mode_nxt;
  logic [1:0]          lock_mode_nxt;
  logic                stop_key_nxt;
  logic                restart_nxt;
  logic                stop_nxt;
  logic [2:0]          display_nxt;

  assign wr_ol_mode = wr_ok & idx_is(req_idx, dtp_pkg::IDX_OL_MODE);
  assign wr_lock    = wr_ok & idx_is(req_idx, dtp_pkg::IDX_LOCK);
  assign wr_init    = wr_ok & idx_is(req_idx, dtp_pkg::IDX_INIT);
  assign wr_key     = wr_ok & idx_is(req_idx, dtp_pkg::IDX_STOP_KEY);
  assign wr_restart = wr_ok & idx_is(req_idx, dtp_pkg::IDX_RESTART);
  assign wr_stop    = wr_ok & idx_is(req_idx, dtp_pkg::IDX_STOP);
  assign wr_display = wr_ok & idx_is(req_idx, dtp_pkg::IDX_DISPLAY);

  assign ol_mode_nxt   = wr_ol_mode ? req_wdata[1:0] : ol_mode_r;
  assign lock_mode_nxt = wr_lock ? req_wdata[1:0] : lock_mode_r;
  assign stop_key_nxt  = wr_key ? req_wdata[0] : stop_key_r;
  assign restart_nxt   = wr_restart ? req_wdata[0] : restart_r;
  assign stop_nxt      = wr_stop ? req_wdata[0] : stop_r;
  assign display_nxt   = wr_display ? req_wdata[2:0] : display_r;

  // ---------------------------------------------------------------------
  // Decoded control next values
  // ---------------------------------------------------------------------
  dtp_pkg::dtp_lock_t  lock_nxt;
  logic                ol_accel_nxt;
  logic                ol_const_nxt;
  logic                trip_clear_nxt;
  logic                defaults_nxt;

  assign lock_nxt       = dtp_pkg::dtp_lock_eval(lock_mode_nxt,
                                                 lock_input_terminal);
  assign ol_accel_nxt   = ol_mode_nxt == dtp_pkg::OL_ACCEL_CONST;
  assign ol_const_nxt   = ol_mode_nxt != dtp_pkg::OL_OFF;
  // An initialization write is a command: it pulses for one cycle.
  assign trip_clear_nxt = wr_init &&
                          ((req_wdata == dtp_pkg::INIT_TRIP) ||
                           (req_wdata == dtp_pkg::INIT_BOTH));
  assign defaults_nxt   = wr_init &&
                          ((req_wdata == dtp_pkg::INIT_PARAMS) ||
                           (req_wdata == dtp_pkg::INIT_BOTH));

  // ---------------------------------------------------------------------
  // Shadow registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ol_mode_r   <= dtp_pkg::REG_RESET[dtp_pkg::IDX_OL_MODE][1:0];
      lock_mode_r <= dtp_pkg::REG_RESET[dtp_pkg::IDX_LOCK][1:0];
      stop_key_r  <= dtp_pkg::REG_RESET[dtp_pkg::IDX_STOP_KEY][0];
      restart_r   <= dtp_pkg::REG_RESET[dtp_pkg::IDX_RESTART][0];
      stop_r      <= dtp_pkg::REG_RESET[dtp_pkg::IDX_STOP][0];
      display_r   <= dtp_pkg::REG_RESET[dtp_pkg::IDX_DISPLAY][2:0];
    end else if (clk_en) begin
      ol_mode_r   <= ol_mode_nxt;
      lock_mode_r <= lock_mode_nxt;
      stop_key_r  <= stop_key_nxt;
      restart_r   <= restart_nxt;
      stop_r      <= stop_nxt;
      display_r   <= display_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      locked_r     <= 1'b0;
      freq_ok_r    <= 1'b1;
      // Flags start from the reset codes, not from zero.
      ol_accel_r   <= dtp_pkg::REG_RESET[dtp_pkg::IDX_OL_MODE][1:0] ==
                      dtp_pkg::OL_ACCEL_CONST;
      ol_const_r   <= dtp_pkg::REG_RESET[dtp_pkg::IDX_OL_MODE][1:0] !=
                      dtp_pkg::OL_OFF;
      trip_clear_r <= 1'b0;
      defaults_r   <= 1'b0;
      key_en_r     <= dtp_pkg::REG_RESET[dtp_pkg::IDX_STOP_KEY][0] ==
                      dtp_pkg::KEY_ENABLED;
      match_r      <= dtp_pkg::REG_RESET[dtp_pkg::IDX_RESTART][0] ==
                      dtp_pkg::RESTART_MATCH;
      coast_r      <= dtp_pkg::REG_RESET[dtp_pkg::IDX_STOP][0] ==
                      dtp_pkg::STOP_COAST;
    end else if (clk_en) begin
      locked_r     <= lock_nxt.locked;
      freq_ok_r    <= lock_nxt.freq_ok;
      ol_accel_r   <= ol_accel_nxt;
      ol_const_r   <= ol_const_nxt;
      trip_clear_r <= trip_clear_nxt;
      defaults_r   <= defaults_nxt;
      key_en_r     <= stop_key_nxt == dtp_pkg::KEY_ENABLED;
      match_r      <= restart_nxt == dtp_pkg::RESTART_MATCH;
      coast_r      <= stop_nxt == dtp_pkg::STOP_COAST;
    end
  end

  assign param_write_locked     = locked_r;
  assign freq_setting_write_ok  = freq_ok_r;
  assign overload_limit_accel   = ol_accel_r;
  assign overload_limit_const   = ol_const_r;
  assign trip_history_clear     = trip_clear_r;
  assign param_defaults_restore = defaults_r;
  assign stop_key_enabled       = key_en_r;
  assign coast_restart_match    = match_r;
  assign coast_to_stop          = coast_r;
  assign display_select         = display_r;

  // ---------------------------------------------------------------------
  // Answer pipeline
  // ---------------------------------------------------------------------
  // Read data leaves the store one cycle after the request, so the answer
  // stands two enabled edges behind it; requests may follow back to back.
  dtp_pkg::dtp_word_t  resp_data_nxt;

  assign resp_data_nxt = (p1_err_r != dtp_pkg::ERR_NONE) ? '0 :
                         p1_write_r ? p1_wdata_r : st.rdata;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      p1_valid_r <= 1'b0;
      p1_write_r <= 1'b0;
      p1_err_r   <= dtp_pkg::ERR_NONE;
      p1_wdata_r <= '0;
    end else if (clk_en) begin
      p1_valid_r <= req_valid;
      p1_write_r <= req_write;
      p1_err_r   <= req_err;
      p1_wdata_r <= req_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_valid_r <= 1'b0;
      resp_rdata_r <= '0;
      resp_err_r   <= dtp_pkg::ERR_NONE;
    end else if (clk_en) begin
      resp_valid_r <= p1_valid_r;
      resp_rdata_r <= p1_valid_r ? resp_data_nxt : '0;
      resp_err_r   <= p1_valid_r ? p1_err_r : dtp_pkg::ERR_NONE;
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp_rdata = resp_rdata_r;
  assign resp_err   = resp_err_r;

endmodule : dtp_param_bank

// ==== tb/dtp_param_bank_asserts.sv ====
// Port-level checker for the tuning parameter bank, bound to its top.
`timescale 1ns/1ns
module dtp_param_bank_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic        lock_input_terminal,
  input wire logic        resp_valid,
  input wire logic [7:0]  resp_err,
  input wire logic        param_write_locked,
  input wire logic        freq_setting_write_ok,
  input wire logic        trip_history_clear,
  input wire logic        param_defaults_restore,
  input wire logic        stop_key_enabled,
  input wire logic [2:0]  display_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_take;
    clk_en && req_valid;
  endsequence
  // An open write is one that no lock can refuse at its taking edge.
  sequence s_open;
    s_take ##0 (req_write && !param_write_locked && !lock_input_terminal);
  endsequence
  a_resp_latency: assert property (
    s_take ##1 clk_en |=> resp_valid)
    else $error("answer missing two edges after a request");
  a_gap_addr: assert property (s_take ##0 req_addr == 16'h0097
    ##1 clk_en |=> resp_err == dtp_pkg::ERR_BAD_ADDR)
    else $error("unlisted address not refused");
  a_ro_refused: assert property (s_take ##0 (req_write
    && req_addr == 16'h009b) ##1 clk_en
    |=> resp_err == dtp_pkg::ERR_READ_ONLY)
    else $error("read-only write not refused");
  a_lock_refuse: assert property (s_take ##0 (req_write
    && req_addr == 16'h0093 && lock_input_terminal && param_write_locked
    && !freq_setting_write_ok) ##1 clk_en
    |=> resp_err == dtp_pkg::ERR_LOCKED) else $error("locked write taken");
  a_freq_ok: assert property (
    !param_write_locked |-> freq_setting_write_ok)
    else $error("frequency setting blocked while unlocked");
  a_display_load: assert property (s_open ##0 (req_addr == 16'h00e9
    && req_wdata inside {[16'h0001:16'h0007]})
    |=> display_select == $past(req_wdata[2:0]))
    else $error("display code not applied");
  a_init_both: assert property (s_open ##0 (req_addr == 16'h009a
    && req_wdata == 16'h0002) |=> trip_history_clear
    && param_defaults_restore) else $error("init pulses missing");
  a_key_enable: assert property (s_open ##0 (req_addr == 16'h009d
    && req_wdata[15:1] == 15'h0000)
    |=> stop_key_enabled != $past(req_wdata[0]))
    else $error("stop key enable not applied");
  a_init_codes: assert property (s_open ##0 (req_addr == 16'h009a
    && req_wdata < 16'h0002) |=> trip_history_clear
    == ($past(req_wdata[0]) == 1'b0) && param_defaults_restore
    == $past(req_wdata[0])) else $error("init code pulses wrong");
endmodule : dtp_param_bank_asserts
bind dtp_param_bank dtp_param_bank_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid),
  .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
  .lock_input_terminal(lock_input_terminal), .resp_valid(resp_valid),
  .resp_err(resp_err), .param_write_locked(param_write_locked),
  .freq_setting_write_ok(freq_setting_write_ok),
  .trip_history_clear(trip_history_clear),
  .param_defaults_restore(param_defaults_restore),
  .stop_key_enabled(stop_key_enabled), .display_select(display_select));

// ==== tb/dtp_net_master.sv ====
// Network master model issuing one holding-register request at a time.
`timescale 1ns/1ns
module dtp_net_master (
  input  wire logic        clk,
  input  wire logic        resp_valid,
  input  wire logic [15:0] resp_rdata,
  input  wire logic [7:0]  resp_err,
  output logic             req_valid,
  output logic             req_write,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end
  // Idle lines carry the inverse of the last request so stale data is seen.
  task automatic xfer(input logic wr, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] rd,
                      output logic [7:0] er, output bit ok);
    ok = 1'b0;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_write = ~wr;
    req_addr  = ~a;
    req_wdata = ~d;
    for (int i = 0; i < 6 && !ok; i++) begin
      @(posedge clk);
      #1;
      if (resp_valid === 1'b1) begin
        ok = 1'b1;
        rd = resp_rdata;
        er = resp_err;
      end
    end
  endtask : xfer
endmodule : dtp_net_master

// ==== tb/tb_drive_tuning_param_bank.sv ====
// Self-checking bench for the drive tuning parameter bank.
`timescale 1ns/1ns
module tb_drive_tuning_param_bank;
  logic        clk, rst_n, clk_en, lock_input_terminal;
  logic        req_valid, req_write, resp_valid;
  logic [15:0] req_addr, req_wdata, resp_rdata;
  logic [7:0]  resp_err;
  logic [9:0]  outs;
  logic [1:0]  pulses;
  int          miscompares = 0;
  int          tests_run = 0;
  int          model[int], lo[int], hi[int];
  dtp_param_bank DUT (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .lock_input_terminal(lock_input_terminal),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_err(resp_err),
    .param_write_locked(outs[9]), .freq_setting_write_ok(outs[8]),
    .overload_limit_accel(outs[7]), .overload_limit_const(outs[6]),
    .trip_history_clear(pulses[1]), .param_defaults_restore(pulses[0]),
    .stop_key_enabled(outs[5]), .coast_restart_match(outs[4]),
    .coast_to_stop(outs[3]), .display_select(outs[2:0]));
  dtp_net_master u_master (.clk(clk), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .resp_err(resp_err), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata));
  always #2 clk = ~clk;
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic init_model;
    for (int i = 0; i < dtp_pkg::NUM_REGS; i++) begin
      model[dtp_pkg::REG_ADDR[i]] = dtp_pkg::REG_RESET[i];
      lo[dtp_pkg::REG_ADDR[i]] = dtp_pkg::REG_MIN[i];
      hi[dtp_pkg::REG_ADDR[i]] = dtp_pkg::REG_MAX[i];
    end
  endtask : init_model
  // Refusal order is address, read-only, lock, then range.
  task automatic access(input logic wr, input int a, input int d);
    logic [15:0] rd;
    logic [7:0]  er, xe;
    int          xd, m, k;
    bit          ok;
    m  = model[16'h0095];
    xd = 0;
    if (!model.exists(a)) xe = dtp_pkg::ERR_BAD_ADDR;
    else if (wr && a == 16'h009b) xe = dtp_pkg::ERR_READ_ONLY;
    else if (wr && a != 16'h0095 && (m > 1 || lock_input_terminal))
      xe = dtp_pkg::ERR_LOCKED;
    else if (wr && (d < lo[a] || d > hi[a])) xe = dtp_pkg::ERR_BAD_VALUE;
    else begin
      xe = dtp_pkg::ERR_NONE;
      if (wr) model[a] = d;
      xd = model[a];
    end
    u_master.xfer(wr, a[15:0], d[15:0], rd, er, ok);
    if (!ok) begin
      miscompares++;
      $display("unexpected answer at %h: expected one, seen none", a[15:0]);
      finish_test();
    end else begin
      check("resp_err", {8'h00, xe}, {8'h00, er});
      check("resp_rdata", xd[15:0], rd);
      m = model[16'h0095];
      k = model[16'h0092];
      check("decoded outputs", {6'h00, m > 1 || lock_input_terminal,
        !(m > 1 || lock_input_terminal) || m[0], k == 1, k == 1 || k == 2,
        model[16'h009d] == 0, model[16'h009e] == 1, model[16'h00a0] == 1,
        model[16'h00e9][2:0]}, {6'h00, outs});
    end
  endtask : access
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    lock_input_terminal = 1'b0;
    void'($urandom(35));
    init_model();
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    foreach (model[a]) access(1'b0, a, 0);
    $display("test reset_values done");
    foreach (lo[a]) begin
      if (a != 16'h009b) begin
        access(1'b1, a, lo[a] - 1);
        access(1'b1, a, hi[a] + 1);
        access(1'b1, a, lo[a] + $urandom_range(hi[a] - lo[a]));
        access(1'b0, a, 0);
        for (int v = lo[a]; v <= hi[a] && hi[a] < 8; v++)
          access(1'b1, a, v);
        access(1'b1, a, hi[a]);
        access(1'b1, a, lo[a]);
      end
    end
    $display("test ranges done");
    access(1'b1, 16'h009b, $urandom_range(16'hffff));
    access(1'b0, 16'h009b, 0);
    access(1'b1, 16'h0097, 1);
    repeat (6) access(1'b0, $urandom_range(16'hffff), 0);
    $display("test refusals done");
    for (int m = 0; m < 4; m++) begin
      for (int t = 0; t < 2; t++) begin
        access(1'b1, 16'h0095, m);
        lock_input_terminal = t[0];
        access(1'b1, 16'h0093, 2000 + m);
        access(1'b1, 16'h0095, 0);
        lock_input_terminal = 1'b0;
      end
    end
    $display("test lock_modes done");
    // Freeze while a read is in flight.
    fork
      access(1'b0, 16'h0093, 0);
      begin
        repeat (2) @(posedge clk);
        #1;
        clk_en = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        clk_en = 1'b1;
      end
    join
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    init_model();
    foreach (model[a]) access(1'b0, a, 0);
    $display("test freeze_reset done");
    finish_test();
  end
endmodule : tb_drive_tuning_param_bank
